/* File: logic/pllcg_consts.svh */
// Constants for the clock generation chain: divide counts and timing figures
`ifndef PLLCG_CONSTS_SVH
`define PLLCG_CONSTS_SVH

// ------------------------------------------------------------------
// PLL indices
// ------------------------------------------------------------------
`define PLLCG_IDX_INT        0
`define PLLCG_IDX_LS         1
`define PLLCG_IDX_HS         2
`define PLLCG_IDX_DOT        3
`define PLLCG_NUM_PLL        4

// ------------------------------------------------------------------
// Feedback divide counts (multiplication factors)
// ------------------------------------------------------------------
`define PLLCG_INT_FB_DIV     6'h2d
`define PLLCG_LS_FB_DIV      6'h19
`define PLLCG_HS_FB_DIV      6'h09
`define PLLCG_DOT_DIV_BASE   6'h09

// ------------------------------------------------------------------
// Reference and output dividers
// ------------------------------------------------------------------
`define PLLCG_DOT_REF_DIV    6'h10
`define PLLCG_HS_REF_DIV     6'h05
`define PLLCG_CPU_DIV        6'h02
`define PLLCG_TIMER_DIV      6'h1f
`define PLLCG_NUM_RDIV       4
`define PLLCG_RDIV_DOT       0
`define PLLCG_RDIV_HS        1
`define PLLCG_RDIV_CPU       2
`define PLLCG_RDIV_TIMER     3

// ------------------------------------------------------------------
// RTC reset pulse length
// ------------------------------------------------------------------
`define PLLCG_RTC_RST_NS     1000
`define PLLCG_CLK_NS         25
`define PLLCG_RTC_RST_CYC    ((`PLLCG_RTC_RST_NS + `PLLCG_CLK_NS - 1) / `PLLCG_CLK_NS)

`endif

/* File: logic/pllcg_pkg.sv */
// Types shared by the clock generation chain
`default_nettype none
package pllcg_pkg;
	typedef logic [5:0] pllcg_cnt_t;   // Divider count

	// RTC one-shot states, Gray along WAIT, PULSE, DONE (WAIT to DONE changes both bits)
	typedef enum logic [1:0] {
		PLLCG_OS_WAIT  = 2'h0,
		PLLCG_OS_PULSE = 2'h1,
		PLLCG_OS_DONE  = 2'h3
	} pllcg_os_e;
endpackage : pllcg_pkg
`default_nettype wire

/* File: logic/pllcg_clock_gen.sv */
// Digital part of the clock generation chain: dividers, phase detectors, RTC reset
// ------------------------------------------------------------------
// What this block does
// RULE1: Up when reference leads, down when feedback leads
// RULE2: Intermediate PLL feedback divides by 45
// RULE3: Low-speed PLL multiplies intermediate output by 25
// RULE4: Dot-clock reference is low-speed output over 16
// RULE5: Ratio code 000..111 selects divider 9..16
// RULE6: User waits for stabilization after ratio change
// RULE7: High-speed reference is low-speed over five, feedback nine
// RULE8: High-speed output clocks DRAM at full rate
// RULE9: High-speed output halved for CPU core PLL
// RULE10: Low battery at power-up asserts RTC reset
// RULE11: One-shot gives a single RTC reset pulse
// RULE12: System reset drives RTC isolation power-down
// RULE13: Timer clock internal or external clock pin
// RULE14: New ratio applied at divider count boundary
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pllcg_consts.svh"

module pllcg_clock_gen #(
	parameter int RTC_RST_CYC = `PLLCG_RTC_RST_CYC   // RTC reset pulse length
) (
	input  wire logic       mclk_i,                 // 40 MHz clock
	input  wire logic       reset_n_i,              // Async reset, active low
	input  wire logic       slow_crystal_in_i,      // 32.768 kHz reference tick
	input  wire logic       int_vco_tick_i,         // Intermediate VCO tick
	input  wire logic       ls_vco_tick_i,          // Low-speed VCO tick
	input  wire logic       hs_vco_tick_i,          // High-speed VCO tick
	input  wire logic       dot_vco_tick_i,         // Dot-clock VCO tick
	input  wire logic [2:0] dot_clock_ratio_sel_i,  // Dot-clock ratio code
	input  wire logic       batt_low_i,             // Backup battery below threshold
	input  wire logic       sys_reset_n_i,          // System reset pin, active low
	input  wire logic       timer_src_ext_i,        // 1 selects external timer clock
	input  wire logic       clk_io_i,               // External timer clock pin
	output logic      [3:0] pd_up_o,                // Phase detector up per PLL
	output logic      [3:0] pd_down_o,              // Phase detector down per PLL
	output logic      [3:0] fb_tick_o,              // Feedback divider tick per PLL
	output logic            int_clk_o,              // Intermediate PLL output tick
	output logic            ls_clk_o,               // Low-speed PLL output tick
	output logic            dot_clk_o,              // Dot clock tick
	output logic            dram_clk_o,             // DRAM controller clock tick
	output logic            dot_ref_o,              // Dot-clock PLL reference tick
	output logic            hs_ref_o,               // High-speed PLL reference tick
	output logic            cpu_pll_ref_o,          // CPU core PLL input tick
	output logic            interval_timer_clk_o,   // Interval timer clock tick
	output logic      [5:0] dot_div_o,              // Dot-clock divider in use
	output logic            rtc_reset_o,            // RTC reset pulse
	output logic            rtc_power_down_o        // RTC isolation
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (RTC_RST_CYC < 1 || RTC_RST_CYC > 65535) begin : g_chk
		$error("RTC_RST_CYC out of range");
	end

	// ------------------------------------------------------------------
	// Per-PLL wiring
	// ------------------------------------------------------------------
	logic                 ref_tick [`PLLCG_NUM_PLL];   // Reference tick per PLL
	logic                 vco_tick [`PLLCG_NUM_PLL];   // VCO tick per PLL
	pllcg_pkg::pllcg_cnt_t fb_div  [`PLLCG_NUM_PLL];   // Feedback divide count
	logic                 fb_wrap  [`PLLCG_NUM_PLL];   // Feedback count boundary
	logic                 rdiv_in  [`PLLCG_NUM_RDIV];  // Ref divider input ticks
	logic                 rdiv_out [`PLLCG_NUM_RDIV];  // Ref divider output ticks
	pllcg_pkg::pllcg_cnt_t dot_div;                    // Dot divider in use
	pllcg_pkg::pllcg_cnt_t next_dot_div;               // Next dot divider
	logic                 clk_io_q;                    // Previous pin level
	logic                 ext_edge;                    // External pin rising edge

	assign vco_tick[`PLLCG_IDX_INT] = int_vco_tick_i;
	assign vco_tick[`PLLCG_IDX_LS]  = ls_vco_tick_i;
	assign vco_tick[`PLLCG_IDX_HS]  = hs_vco_tick_i;
	assign vco_tick[`PLLCG_IDX_DOT] = dot_vco_tick_i;

	// Reference chain
	assign ref_tick[`PLLCG_IDX_INT] = slow_crystal_in_i;
	assign ref_tick[`PLLCG_IDX_LS]  = int_vco_tick_i;                // see RULE3
	assign ref_tick[`PLLCG_IDX_HS]  = rdiv_out[`PLLCG_RDIV_HS];      // see RULE7
	assign ref_tick[`PLLCG_IDX_DOT] = rdiv_out[`PLLCG_RDIV_DOT];     // see RULE4

	// Feedback divide counts
	assign fb_div[`PLLCG_IDX_INT] = `PLLCG_INT_FB_DIV;               // see RULE2
	assign fb_div[`PLLCG_IDX_LS]  = `PLLCG_LS_FB_DIV;                // see RULE3
	assign fb_div[`PLLCG_IDX_HS]  = `PLLCG_HS_FB_DIV;                // see RULE7
	assign fb_div[`PLLCG_IDX_DOT] = dot_div;                         // see RULE5

	// Reference and output divider inputs
	assign rdiv_in[`PLLCG_RDIV_DOT]   = ls_vco_tick_i;
	assign rdiv_in[`PLLCG_RDIV_HS]    = ls_vco_tick_i;
	assign rdiv_in[`PLLCG_RDIV_CPU]   = hs_vco_tick_i;               // see RULE9
	assign rdiv_in[`PLLCG_RDIV_TIMER] = ls_vco_tick_i;

	// ------------------------------------------------------------------
	// Feedback divider and phase detector per PLL
	// ------------------------------------------------------------------
	for (genvar i = 0; i < `PLLCG_NUM_PLL; i++) begin : g_pll
		pllcg_pkg::pllcg_cnt_t cnt;        // Feedback count
		pllcg_pkg::pllcg_cnt_t next_cnt;   // Next feedback count
		logic                 up;          // Up state
		logic                 down;        // Down state
		logic                 next_up;     // Next up
		logic                 next_down;   // Next down
		logic                 fb;          // Feedback tick
		logic                 fb_q;        // Registered feedback tick

		// Feedback tick on the last VCO tick of each division
		assign fb_wrap[i] = vco_tick[i] && (cnt == fb_div[i] - 6'h01);
		assign fb = fb_wrap[i];

		// Next count and detector state
		always_comb begin
			next_cnt = cnt;
			if (fb_wrap[i]) begin
				next_cnt = 6'h00;
			end else if (vco_tick[i]) begin
				next_cnt = cnt + 6'h01;
			end
			// Leading edge sets its flag; both set clears both
			next_up   = up   || ref_tick[i];                         // see RULE1
			next_down = down || fb;                                  // see RULE1
			if (next_up && next_down) begin
				next_up   = 1'b0;
				next_down = 1'b0;
			end
		end

		// Register the divider and detector
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				cnt  <= 6'h00;
				up   <= 1'b0;
				down <= 1'b0;
				fb_q <= 1'b0;
			end else begin
				cnt  <= next_cnt;
				up   <= next_up;
				down <= next_down;
				fb_q <= fb;
			end
		end

		assign pd_up_o[i]   = up;
		assign pd_down_o[i] = down;
		assign fb_tick_o[i] = fb_q;
	end

	// ------------------------------------------------------------------
	// Reference and output dividers
	// ------------------------------------------------------------------
	localparam pllcg_pkg::pllcg_cnt_t RDIV_N [`PLLCG_NUM_RDIV] = '{
		`PLLCG_DOT_REF_DIV, `PLLCG_HS_REF_DIV, `PLLCG_CPU_DIV, `PLLCG_TIMER_DIV
	};

	for (genvar j = 0; j < `PLLCG_NUM_RDIV; j++) begin : g_rdiv
		pllcg_pkg::pllcg_cnt_t cnt;        // Divider count
		pllcg_pkg::pllcg_cnt_t next_cnt;   // Next divider count

		// One output tick per N input ticks
		assign rdiv_out[j] = rdiv_in[j] && (cnt == RDIV_N[j] - 6'h01);

		always_comb begin
			next_cnt = cnt;
			if (rdiv_out[j]) begin
				next_cnt = 6'h00;
			end else if (rdiv_in[j]) begin
				next_cnt = cnt + 6'h01;
			end
		end

		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				cnt <= 6'h00;
			end else begin
				cnt <= next_cnt;
			end
		end
	end

	// ------------------------------------------------------------------
	// Dot-clock ratio, applied only at the feedback boundary
	// ------------------------------------------------------------------
	always_comb begin
		next_dot_div = dot_div;
		if (fb_wrap[`PLLCG_IDX_DOT]) begin                          // see RULE14
			next_dot_div = `PLLCG_DOT_DIV_BASE + {3'h0, dot_clock_ratio_sel_i}; // see RULE5
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dot_div <= `PLLCG_DOT_DIV_BASE;
		end else begin
			dot_div <= next_dot_div;
		end
	end

	// ------------------------------------------------------------------
	// Clock tick outputs and timer source
	// ------------------------------------------------------------------
	logic next_timer;   // Selected timer tick

	assign ext_edge = clk_io_i && !clk_io_q;

	always_comb begin
		if (timer_src_ext_i) begin                                  // see RULE13
			next_timer = ext_edge;
		end else begin
			next_timer = rdiv_out[`PLLCG_RDIV_TIMER];
		end
	end

	// Register every tick output
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			clk_io_q             <= 1'b0;
			int_clk_o            <= 1'b0;
			ls_clk_o             <= 1'b0;
			dot_clk_o            <= 1'b0;
			dram_clk_o           <= 1'b0;
			dot_ref_o            <= 1'b0;
			hs_ref_o             <= 1'b0;
			cpu_pll_ref_o        <= 1'b0;
			interval_timer_clk_o <= 1'b0;
			dot_div_o            <= `PLLCG_DOT_DIV_BASE;
		end else begin
			clk_io_q             <= clk_io_i;
			int_clk_o            <= int_vco_tick_i;
			ls_clk_o             <= ls_vco_tick_i;
			dot_clk_o            <= dot_vco_tick_i;
			dram_clk_o           <= hs_vco_tick_i;                   // see RULE8
			dot_ref_o            <= rdiv_out[`PLLCG_RDIV_DOT];       // see RULE4
			hs_ref_o             <= rdiv_out[`PLLCG_RDIV_HS];        // see RULE7
			cpu_pll_ref_o        <= rdiv_out[`PLLCG_RDIV_CPU];       // see RULE9
			interval_timer_clk_o <= next_timer;                      // see RULE13
			dot_div_o            <= next_dot_div;
		end
	end

	// ------------------------------------------------------------------
	// RTC voltage monitor: one-shot reset and power-down isolation
	// ------------------------------------------------------------------
	pllcg_pkg::pllcg_os_e os_state;       // One-shot state
	pllcg_pkg::pllcg_os_e next_os_state;  // Next one-shot state
	logic [15:0]          os_cnt;         // Pulse length count
	logic [15:0]          next_os_cnt;    // Next pulse length count
	logic                 next_rtc_reset; // Next RTC reset level

	// Sample battery once after power-up; fire at most one pulse
	always_comb begin
		next_os_state  = os_state;
		next_os_cnt    = os_cnt;
		next_rtc_reset = 1'b0;
		case (os_state)
			pllcg_pkg::PLLCG_OS_WAIT: begin
				if (batt_low_i) begin                                // see RULE10
					next_os_state  = pllcg_pkg::PLLCG_OS_PULSE;
					next_os_cnt    = 16'(RTC_RST_CYC - 1);
					next_rtc_reset = 1'b1;
				end else begin
					next_os_state = pllcg_pkg::PLLCG_OS_DONE;
				end
			end
			pllcg_pkg::PLLCG_OS_PULSE: begin
				if (os_cnt == 16'h0000) begin
					next_os_state = pllcg_pkg::PLLCG_OS_DONE;        // see RULE11
				end else begin
					next_os_cnt    = os_cnt - 16'h0001;
					next_rtc_reset = 1'b1;
				end
			end
			default: begin
				next_os_state = pllcg_pkg::PLLCG_OS_DONE;            // see RULE11
			end
		endcase
	end

	// Register one-shot and isolation
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			os_state         <= pllcg_pkg::PLLCG_OS_WAIT;
			os_cnt           <= 16'h0000;
			rtc_reset_o      <= 1'b0;
			rtc_power_down_o <= 1'b0;
		end else begin
			os_state         <= next_os_state;
			os_cnt           <= next_os_cnt;
			rtc_reset_o      <= next_rtc_reset;
			rtc_power_down_o <= !sys_reset_n_i;                      // see RULE12
		end
	end

endmodule : pllcg_clock_gen
`default_nettype wire

/* File: verification/pllcg_clock_gen_props.sv */
// Concurrent checks on the ports of the clock generation chain
`timescale 1ns/1ps
`default_nettype none
module pllcg_clock_gen_props #(
	parameter int RTC_RST_CYC = 40  // RTC pulse length
) (
	input wire logic       mclk_i,
	input wire logic       reset_n_i,
	input wire logic       slow_crystal_in_i,
	input wire logic       int_vco_tick_i,
	input wire logic       ls_vco_tick_i,
	input wire logic       hs_vco_tick_i,
	input wire logic       dot_vco_tick_i,
	input wire logic [2:0] dot_clock_ratio_sel_i,
	input wire logic       sys_reset_n_i,
	input wire logic [3:0] pd_up_o,
	input wire logic [3:0] pd_down_o,
	input wire logic [3:0] fb_tick_o,
	input wire logic       int_clk_o,
	input wire logic       dot_clk_o,
	input wire logic       dram_clk_o,
	input wire logic       dot_ref_o,
	input wire logic       hs_ref_o,
	input wire logic       cpu_pll_ref_o,
	input wire logic [5:0] dot_div_o,
	input wire logic       rtc_reset_o,
	input wire logic       rtc_power_down_o
);
	logic [7:0] hi_cnt;       // High cycles of the RTC pulse
	logic [7:0] next_hi_cnt;  // Next value of hi_cnt
	// Count consecutive high cycles of the RTC reset
	always_comb begin
		next_hi_cnt = rtc_reset_o ? hi_cnt + 8'h01 : 8'h00;
	end
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hi_cnt <= 8'h00;
		end else begin
			hi_cnt <= next_hi_cnt;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_pd_up_cause: assert property ($rose(pd_up_o[0]) |-> $past(slow_crystal_in_i))
		else $error("phase up without reference tick");
	a_pd_down_cause: assert property ($rose(pd_down_o[0]) |-> fb_tick_o[0])
		else $error("phase down without feedback wrap");
	a_power_down: assert property ($past(reset_n_i) |->
		rtc_power_down_o == !$past(sys_reset_n_i))
		else $error("power-down does not follow system reset");
	a_ls_ref_tick: assert property ((hs_ref_o || dot_ref_o) |->
		$past(ls_vco_tick_i))
		else $error("divided reference without low-speed tick");
	a_cpu_ref_half: assert property (cpu_pll_ref_o |-> $past(hs_vco_tick_i) ##1 !cpu_pll_ref_o)
		else $error("cpu reference not a halved tick");
	a_dram_full: assert property ($past(reset_n_i) |->
		dram_clk_o == $past(hs_vco_tick_i))
		else $error("dram clock not the high-speed tick");
	a_int_clk_copy: assert property ($past(reset_n_i) |->
		int_clk_o == $past(int_vco_tick_i))
		else $error("intermediate output not the vco tick");
	a_dot_clk_copy: assert property ($past(reset_n_i) |->
		dot_clk_o == $past(dot_vco_tick_i))
		else $error("dot clock not the dot vco tick");
	a_dot_div_wrap: assert property ($changed(dot_div_o) |->
		fb_tick_o[3] && dot_div_o == {3'h0, $past(dot_clock_ratio_sel_i)} + 6'h09)
		else $error("dot divider changed off a wrap or wrongly");
	a_rtc_pulse_len: assert property ($fell(rtc_reset_o) |-> int'(hi_cnt) == RTC_RST_CYC)
		else $error("rtc reset pulse length wrong");
	c_rtc_pulse: cover property ($fell(rtc_reset_o));
	c_pd_down: cover property ($rose(pd_down_o[0]));
	c_dot_change: cover property ($changed(dot_div_o));
endmodule : pllcg_clock_gen_props
`default_nettype wire

/* File: verification/pllcg_consumer.sv */
// Consumer model: peripherals and CPU counting the clock ticks they receive
`timescale 1ns/1ps
`default_nettype none
module pllcg_consumer (
	input  wire logic        mclk_i,     // System clock
	input  wire logic        reset_n_i,  // Async reset, active low
	input  wire logic [8:0]  tick_i,     // Ticks received per consumer
	output logic      [15:0] cnt_o [9]   // Ticks counted per consumer
);
	logic [15:0] next_cnt [9];  // Next counts
	// Each consumer counts its clock ticks
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			next_cnt[i] = cnt_o[i] + {15'h0000, tick_i[i]};
		end
	end
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_o <= '{default: 16'h0000};
		end else begin
			cnt_o <= next_cnt;
		end
	end
endmodule : pllcg_consumer
`default_nettype wire

/* File: verification/pll_clock_generator_bench.sv */
// Self-checking bench for the clock generation chain
`timescale 1ns/1ps
`default_nettype none
module pll_clock_generator_bench;
	localparam int RTC_RST_CYC = 4;  // Short RTC pulse
	logic mclk_i, reset_n_i, slow_crystal_in_i, int_vco_tick_i, ls_vco_tick_i;
	logic hs_vco_tick_i, dot_vco_tick_i, batt_low_i, sys_reset_n_i, timer_src_ext_i, clk_io_i;
	logic [2:0] dot_clock_ratio_sel_i;
	logic [3:0] pd_up_o, pd_down_o, fb_tick_o;
	logic int_clk_o, ls_clk_o, dot_clk_o, dram_clk_o, dot_ref_o, hs_ref_o, cpu_pll_ref_o;
	logic interval_timer_clk_o, rtc_reset_o, rtc_power_down_o;
	logic [5:0] dot_div_o;
	logic [15:0] cnt [9];  // Consumer tick counts
	int miscompares = 0;
	int total_checks = 0;
	int nl = 0;
	int nh = 0;
	int dv = 9;
	// Rows: ls ticks, hs ticks, then cpu, hs_ref, dot_ref, timer, fb ls, fb hs totals
	int rows [4][8] = '{'{4, 1, 0, 0, 0, 0, 0, 0}, '{1, 1, 1, 1, 0, 0, 0, 0},
		'{11, 3, 2, 3, 1, 0, 0, 0}, '{15, 5, 5, 6, 1, 1, 1, 1}};
	pllcg_clock_gen #(.RTC_RST_CYC(RTC_RST_CYC)) dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
		.slow_crystal_in_i(slow_crystal_in_i), .int_vco_tick_i(int_vco_tick_i),
		.ls_vco_tick_i(ls_vco_tick_i), .hs_vco_tick_i(hs_vco_tick_i),
		.dot_vco_tick_i(dot_vco_tick_i), .dot_clock_ratio_sel_i(dot_clock_ratio_sel_i),
		.batt_low_i(batt_low_i), .sys_reset_n_i(sys_reset_n_i),
		.timer_src_ext_i(timer_src_ext_i), .clk_io_i(clk_io_i), .pd_up_o(pd_up_o),
		.pd_down_o(pd_down_o), .fb_tick_o(fb_tick_o), .int_clk_o(int_clk_o),
		.ls_clk_o(ls_clk_o), .dot_clk_o(dot_clk_o), .dram_clk_o(dram_clk_o),
		.dot_ref_o(dot_ref_o), .hs_ref_o(hs_ref_o), .cpu_pll_ref_o(cpu_pll_ref_o),
		.interval_timer_clk_o(interval_timer_clk_o), .dot_div_o(dot_div_o),
		.rtc_reset_o(rtc_reset_o), .rtc_power_down_o(rtc_power_down_o));
	pllcg_consumer u_consumer (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cnt_o(cnt),
		.tick_i({rtc_reset_o, fb_tick_o[2], fb_tick_o[1], interval_timer_clk_o,
		dot_ref_o, hs_ref_o, cpu_pll_ref_o, dram_clk_o, ls_clk_o}));
	always #12.5 mclk_i = ~mclk_i;
	// Compare and count
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Back-to-back VCO ticks per PLL, then idle until 64 cycles have passed
	task automatic pulse(input int ni, input int nl_, input int nh_, input int nd);
		for (int i = 0; i < 64; i++) begin
			@(negedge mclk_i);
			int_vco_tick_i = (i < ni);
			ls_vco_tick_i = (i < nl_);
			hs_vco_tick_i = (i < nh_);
			dot_vco_tick_i = (i < nd);
		end
	endtask : pulse
	task automatic report_and_stop();
		if (miscompares == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// Watchdog against a hang
	initial begin
		#1ms;
		miscompares++;
		report_and_stop();
	end
	initial begin
		{mclk_i, reset_n_i, slow_crystal_in_i, int_vco_tick_i, ls_vco_tick_i} = 5'h00;
		{hs_vco_tick_i, dot_vco_tick_i, timer_src_ext_i, clk_io_i} = 4'h0;
		{batt_low_i, sys_reset_n_i} = 2'h3;
		dot_clock_ratio_sel_i = 3'h0;
		repeat (3) @(negedge mclk_i);
		check("dot_div_o reset", {10'h000, dot_div_o}, 16'h0009);
		reset_n_i = 1'b1;
		// Divider rows
		for (int r = 0; r < 4; r++) begin
			pulse(0, rows[r][0], rows[r][1], 0);
			nl += rows[r][0];
			nh += rows[r][1];
			check("ls_clk count", cnt[0], 16'(nl));
			check("dram_clk count", cnt[1], 16'(nh));
			for (int k = 2; k < 8; k++) begin
				check("divided tick count", cnt[k], 16'(rows[r][k]));
			end
		end
		check("rtc pulse cycles", cnt[8], 16'(RTC_RST_CYC));
		// Phase detector on the intermediate PLL
		@(negedge mclk_i) slow_crystal_in_i = 1'b1;
		@(negedge mclk_i) slow_crystal_in_i = 1'b0;
		check("pd_up int", {15'h0000, pd_up_o[0]}, 16'h0001);
		pulse(44, 0, 0, 0);
		check("pd_up held", {14'h0000, pd_up_o[0], pd_down_o[0]}, 16'h0002);
		pulse(1, 0, 0, 0);
		check("pd cleared", {14'h0000, pd_up_o[0], pd_down_o[0]}, 16'h0000);
		pulse(45, 0, 0, 0);
		check("pd_down int", {14'h0000, pd_up_o[0], pd_down_o[0]}, 16'h0001);
		// Every ratio code, set at the start of a count, applied only at the wrap
		for (int c = 0; c < 8; c++) begin
			dot_clock_ratio_sel_i = 3'(c);
			pulse(0, 0, 0, dv - 1);
			check("dot_div_o held", {10'h000, dot_div_o}, 16'(dv));
			pulse(0, 0, 0, 1);
			dv = 9 + c;
			check("dot_div_o", {10'h000, dot_div_o}, 16'(dv));
		end
		// System reset isolates the RTC
		@(negedge mclk_i) sys_reset_n_i = 1'b0;
		@(negedge mclk_i) check("power down on", {15'h0000, rtc_power_down_o}, 16'h0001);
		sys_reset_n_i = 1'b1;
		@(negedge mclk_i) check("power down off", {15'h0000, rtc_power_down_o}, 16'h0000);
		// External timer source
		timer_src_ext_i = 1'b1;
		repeat (3) begin
			@(negedge mclk_i) clk_io_i = 1'b1;
			repeat (2) @(negedge mclk_i);
			clk_io_i = 1'b0;
		end
		pulse(0, 0, 0, 0);
		check("timer ext count", cnt[5], 16'h0004);
		// Good battery: no RTC reset after a second reset
		batt_low_i = 1'b0;
		reset_n_i = 1'b0;
		repeat (3) @(negedge mclk_i);
		reset_n_i = 1'b1;
		pulse(0, 0, 0, 0);
		check("rtc no pulse", cnt[8], 16'h0000);
		report_and_stop();
	end
endmodule : pll_clock_generator_bench
bind pllcg_clock_gen pllcg_clock_gen_props #(.RTC_RST_CYC(RTC_RST_CYC)) u_props (
	.mclk_i(mclk_i), .reset_n_i(reset_n_i), .slow_crystal_in_i(slow_crystal_in_i),
	.int_vco_tick_i(int_vco_tick_i), .ls_vco_tick_i(ls_vco_tick_i),
	.hs_vco_tick_i(hs_vco_tick_i), .dot_vco_tick_i(dot_vco_tick_i),
	.dot_clock_ratio_sel_i(dot_clock_ratio_sel_i), .sys_reset_n_i(sys_reset_n_i),
	.pd_up_o(pd_up_o), .pd_down_o(pd_down_o), .fb_tick_o(fb_tick_o),
	.int_clk_o(int_clk_o), .dot_clk_o(dot_clk_o), .dram_clk_o(dram_clk_o),
	.dot_ref_o(dot_ref_o), .hs_ref_o(hs_ref_o), .cpu_pll_ref_o(cpu_pll_ref_o),
	.dot_div_o(dot_div_o), .rtc_reset_o(rtc_reset_o), .rtc_power_down_o(rtc_power_down_o));
`default_nettype wire
